// ==== esw_pkg.sv ====
// Shared constants for the serial write port: frame sizes, modes and host register map.
package esw_pkg;

  // ==========================================================================
  // Serial frame layout
  // ==========================================================================
  localparam int          BYTE_W       = 8;
  localparam int          CNT_W        = 4;
  localparam logic [3:0]  LAST_BIT_4W  = 4'h7;
  localparam logic [3:0]  LAST_BIT_3W  = 4'h8;
  localparam int          FLAG_POS     = 8;
  localparam logic        MODE_4WIRE   = 1'b0;
  localparam logic        MODE_3WIRE   = 1'b1;
  localparam logic        KIND_CMD     = 1'b0;
  localparam logic        KIND_DATA    = 1'b1;
  localparam int          WAKE_CLOCKS  = 2;

  // ==========================================================================
  // Host register map (AXI4-Lite, byte addresses)
  // ==========================================================================
  localparam int          AXI_AW       = 4;
  localparam logic [3:0]  OFS_TX       = 4'h0;
  localparam logic [3:0]  OFS_STATUS   = 4'h4;
  localparam logic [3:0]  OFS_CONFIG   = 4'h8;
  localparam int          TX_KIND_BIT  = 8;
  localparam int          ST_XFER_BIT  = 0;
  localparam int          ST_BUSY_OUT_N_BIT = 1;
  localparam int          ST_MODE_BIT  = 2;
  localparam int          CFG_MODE_BIT = 0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          REF_CLK_HZ   = 40_000_000;
  localparam int          LINK_HZ      = 5_000_000;
  localparam int          HALF_DIV     = REF_CLK_HZ / (2 * LINK_HZ);

  typedef enum logic [4:0] {
    HST_WAKE  = 5'h01,
    HST_IDLE  = 5'h02,
    HST_LOW   = 5'h04,
    HST_HIGH  = 5'h08,
    HST_END   = 5'h10
  } esw_hstate_t;

endpackage : esw_pkg

// ==== esw_link_if.sv ====
// Link wires between the controller and the display's serial write port.
`timescale 1ns/1ps
interface esw_link_if;
  logic serial_clock_in;
  logic host_select_n;
  logic data_command_sel;
  logic serial_in_line;
  logic interface_select_pin;
  logic host_reset_n;
  logic busy_out_n;

  modport dev (
    input  serial_clock_in,
    input  host_select_n,
    input  data_command_sel,
    input  serial_in_line,
    input  interface_select_pin,
    input  host_reset_n,
    output busy_out_n
  );

  modport host (
    output serial_clock_in,
    output host_select_n,
    output data_command_sel,
    output serial_in_line,
    output interface_select_pin,
    output host_reset_n,
    input  busy_out_n
  );
endinterface : esw_link_if

// ==== esw_dev.sv ====
// Display-side serial write port: link receiver and crossing into the core clock.
`timescale 1ns/1ps
module esw_dev (
  esw_link_if.dev               link,
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic             core_busy,
  output logic                  rx_valid,
  output logic [esw_pkg::BYTE_W-1:0] rx_byte,
  output logic                  rx_is_data,
  output logic                  mode_3wire,
  output logic [15:0]           cmd_count,
  output logic [15:0]           data_count
);
  import esw_pkg::*;

  // ==========================================================================
  // Link domain: strap synchroniser
  // ==========================================================================
  // The strap is static, so a plain two-stage synchroniser on the link clock
  // is enough; the host gives a few wake-up clocks before the first frame so
  // that these stages have settled by then.
  logic sel_meta_reg;
  logic sel_sync_reg;

  always_ff @(posedge link.serial_clock_in) begin
    sel_meta_reg <= link.interface_select_pin;
    sel_sync_reg <= sel_meta_reg;
  end

  // ==========================================================================
  // Link domain: bit counter and shift register
  // ==========================================================================
  // The link clock stops between frames, so deselect must clear the counter
  // by itself; it is used as an asynchronous clear together with the reset pin.
  logic                 link_clr;
  logic [CNT_W-1:0]     bit_cnt_reg;
  logic [CNT_W-1:0]     last_bit;
  logic [FLAG_POS:0]    shift_reg;
  logic [FLAG_POS:0]    shift_next;
  logic                 frame_done;

  assign link_clr   = link.host_select_n | ~link.host_reset_n;
  assign last_bit   = (sel_sync_reg == MODE_3WIRE) ? LAST_BIT_3W : LAST_BIT_4W;
  assign shift_next = {shift_reg[FLAG_POS-1:0], link.serial_in_line};
  assign frame_done = (bit_cnt_reg == last_bit);

  always_ff @(posedge link.serial_clock_in or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_reg <= '0;
    end else if (frame_done) begin
      bit_cnt_reg <= '0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge link.serial_clock_in or posedge link_clr) begin
    if (link_clr) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // ==========================================================================
  // Link domain: hold register and event toggle
  // ==========================================================================
  // The hold register stays stable for at least eight link clocks after the
  // toggle flips, far longer than the three core clocks the crossing needs.
  logic [BYTE_W-1:0] hold_byte_reg;
  logic              hold_kind_reg;
  logic              hold_kind_next;
  logic              tog_reg;

  always_comb begin
    if (sel_sync_reg == MODE_3WIRE) begin
      hold_kind_next = shift_next[FLAG_POS];
    end else begin
      hold_kind_next = link.data_command_sel ? KIND_DATA : KIND_CMD;
    end
  end

  always_ff @(posedge link.serial_clock_in or negedge link.host_reset_n) begin
    if (!link.host_reset_n) begin
      hold_byte_reg <= '0;
      hold_kind_reg <= KIND_CMD;
    end else if (!link.host_select_n && frame_done) begin
      hold_byte_reg <= shift_next[BYTE_W-1:0];
      hold_kind_reg <= hold_kind_next;
    end
  end

  always_ff @(posedge link.serial_clock_in or negedge link.host_reset_n) begin
    if (!link.host_reset_n) begin
      tog_reg <= 1'b0;
    end else if (!link.host_select_n && frame_done) begin
      tog_reg <= ~tog_reg;
    end
  end

  // ==========================================================================
  // Core domain: event crossing
  // ==========================================================================
  logic tog_meta_reg;
  logic tog_sync_reg;
  logic tog_prev_reg;
  logic byte_event;

  // Clearing both stages on reset keeps an unknown toggle from posing as a byte.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
    end else begin
      tog_meta_reg <= tog_reg;
      tog_sync_reg <= tog_meta_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tog_prev_reg <= 1'b0;
    end else begin
      tog_prev_reg <= tog_sync_reg;
    end
  end

  assign byte_event = tog_sync_reg ^ tog_prev_reg;

  // ==========================================================================
  // Core domain: delivered byte
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= byte_event;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_byte    <= '0;
      rx_is_data <= KIND_CMD;
    end else if (byte_event) begin
      rx_byte    <= hold_byte_reg;
      rx_is_data <= hold_kind_reg;
    end
  end

  // Counters let the core see how much of each kind has arrived.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmd_count  <= '0;
      data_count <= '0;
    end else if (byte_event) begin
      if (hold_kind_reg == KIND_DATA) begin
        data_count <= data_count + 16'h0001;
      end else begin
        cmd_count  <= cmd_count + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Core domain: strap view and busy output
  // ==========================================================================
  logic csel_meta_reg;
  logic csel_sync_reg;

  always_ff @(posedge ref_clk) begin
    csel_meta_reg <= link.interface_select_pin;
    csel_sync_reg <= csel_meta_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_3wire <= MODE_4WIRE;
    end else begin
      mode_3wire <= csel_sync_reg;
    end
  end

  // The link has no return data path; the busy pin is the only output.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link.busy_out_n <= 1'b1;
    end else begin
      link.busy_out_n <= ~core_busy;
    end
  end

endmodule : esw_dev

// ==== esw_host.sv ====
// Controller side: AXI4-Lite registers driving serial write frames to the display.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module esw_host #(
  parameter int HALF_CYCLES = esw_pkg::HALF_DIV
) (
  esw_link_if.host                      link,
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic [esw_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [esw_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready
);
  import esw_pkg::*;

  // ==========================================================================
  // Busy synchroniser
  // ==========================================================================
  logic busy_meta_reg;
  logic busy_sync_reg;

  always_ff @(posedge ref_clk) begin
    busy_meta_reg <= link.busy_out_n;
    busy_sync_reg <= busy_meta_reg;
  end

  // ==========================================================================
  // AXI4-Lite write side
  // ==========================================================================
  logic [AXI_AW-1:0] aw_addr_reg;
  logic              aw_have_reg;
  logic [31:0]       w_data_reg;
  logic              w_have_reg;
  logic              wr_fire;
  logic              tx_pend_reg;
  logic [8:0]        tx_word_reg;
  logic              cfg_mode_reg;
  logic              xfer_busy;

  assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_reg & ~s_axi_bvalid;
  assign wr_fire       = aw_have_reg & w_have_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  // A transmit word written while a frame is pending is refused with SLVERR.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_reg == OFS_TX) begin
        s_axi_bresp <= xfer_busy ? RESP_SLVERR : RESP_OKAY;
      end else if (aw_addr_reg == OFS_CONFIG) begin
        s_axi_bresp <= xfer_busy ? RESP_SLVERR : RESP_OKAY;
      end else if (aw_addr_reg == OFS_STATUS) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_DECERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // The strap only moves while the link is idle, so it is static to the device.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_mode_reg <= MODE_4WIRE;
    end else if (wr_fire && aw_addr_reg == OFS_CONFIG && !xfer_busy && s_axi_wstrb[0]) begin
      cfg_mode_reg <= w_data_reg[CFG_MODE_BIT];
    end
  end

  // ==========================================================================
  // AXI4-Lite read side
  // ==========================================================================
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == OFS_STATUS) begin
        s_axi_rdata[ST_XFER_BIT]  <= xfer_busy;
        s_axi_rdata[ST_BUSY_OUT_N_BIT] <= busy_sync_reg;
        s_axi_rdata[ST_MODE_BIT]  <= cfg_mode_reg;
      end else if (s_axi_araddr == OFS_CONFIG) begin
        s_axi_rdata[CFG_MODE_BIT] <= cfg_mode_reg;
      end else if (s_axi_araddr != OFS_TX) begin
        s_axi_rresp <= RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Frame engine
  // ==========================================================================
  esw_hstate_t   state_reg;
  logic [15:0]   div_reg;
  logic          half_done;
  logic [3:0]    bit_reg;
  logic [8:0]    shift_reg;
  logic          start_ok;

  assign half_done = (div_reg == 16'(HALF_CYCLES - 1));
  // Commands wait for busy to lift; the device must not be disturbed then.
  assign start_ok  = tx_pend_reg & (tx_word_reg[TX_KIND_BIT] | busy_sync_reg);
  assign xfer_busy = tx_pend_reg | (state_reg != HST_IDLE);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_pend_reg <= 1'b0;
      tx_word_reg <= '0;
    end else if (wr_fire && aw_addr_reg == OFS_TX && !xfer_busy) begin
      tx_pend_reg <= 1'b1;
      tx_word_reg <= w_data_reg[8:0];
    end else if (state_reg == HST_IDLE && start_ok) begin
      tx_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || state_reg == HST_IDLE || half_done) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= HST_WAKE;
      bit_reg   <= '0;
      shift_reg <= '0;
    end else begin
      case (state_reg)
        HST_WAKE: begin
          // Wake clocks with select high let the device's strap stages settle.
          if (half_done && link.serial_clock_in) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == 4'(WAKE_CLOCKS - 1)) begin
              bit_reg   <= '0;
              state_reg <= HST_IDLE;
            end
          end
        end
        HST_IDLE: begin
          if (start_ok) begin
            bit_reg   <= '0;
            state_reg <= HST_LOW;
            if (cfg_mode_reg == MODE_3WIRE) begin
              shift_reg <= tx_word_reg;
            end else begin
              shift_reg <= {tx_word_reg[7:0], 1'b0};
            end
          end
        end
        HST_LOW: begin
          if (half_done) begin
            state_reg <= HST_HIGH;
          end
        end
        HST_HIGH: begin
          if (half_done) begin
            shift_reg <= {shift_reg[7:0], 1'b0};
            bit_reg   <= bit_reg + 4'h1;
            if (bit_reg == ((cfg_mode_reg == MODE_3WIRE) ? LAST_BIT_3W : LAST_BIT_4W)) begin
              state_reg <= HST_END;
            end else begin
              state_reg <= HST_LOW;
            end
          end
        end
        HST_END: begin
          if (half_done) begin
            state_reg <= HST_IDLE;
          end
        end
        default: begin
          state_reg <= HST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Link pins
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link.serial_clock_in <= 1'b0;
    end else if (state_reg == HST_WAKE && half_done) begin
      link.serial_clock_in <= ~link.serial_clock_in;
    end else if (state_reg == HST_LOW && half_done) begin
      link.serial_clock_in <= 1'b1;
    end else if (state_reg == HST_HIGH && half_done) begin
      link.serial_clock_in <= 1'b0;
    end
  end

  // Select stays low from the first bit until half a period after the last edge.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link.host_select_n <= 1'b1;
    end else if (state_reg == HST_IDLE && start_ok) begin
      link.host_select_n <= 1'b0;
    end else if (state_reg == HST_END && half_done) begin
      link.host_select_n <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link.serial_in_line   <= 1'b0;
      link.data_command_sel <= 1'b0;
    end else begin
      // The bit is held through the high phase, so it only moves while the clock is low.
      link.serial_in_line <= (state_reg == HST_LOW || state_reg == HST_HIGH) ? shift_reg[FLAG_POS] : 1'b0;
      if (state_reg == HST_LOW || state_reg == HST_HIGH) begin
        link.data_command_sel <= (cfg_mode_reg == MODE_3WIRE) ? 1'b0 : tx_word_reg[TX_KIND_BIT];
      end else begin
        link.data_command_sel <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    link.interface_select_pin <= cfg_mode_reg;
    link.host_reset_n         <= ~srst;
  end

endmodule : esw_host

// ==== esw_link_monitor.sv ====
// Concurrent checks on the serial link between the controller and the display port.
`timescale 1ns/1ps
module esw_link_monitor #(
  parameter int HALF_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic serial_clock_in,
  input wire logic host_select_n,
  input wire logic data_command_sel,
  input wire logic serial_in_line,
  input wire logic interface_select_pin,
  input wire logic host_reset_n,
  input wire logic busy_out_n
);
  // ==========================================================================
  // Helper counters
  // ==========================================================================
  logic [3:0]  edge_cnt_reg;
  logic [15:0] high_cnt_reg;
  logic [3:0]  busy_cnt_reg;
  logic        sclk_d_reg;

  always_ff @(posedge ref_clk) begin
    sclk_d_reg <= serial_clock_in;
  end

  // Rising link clock edges inside one selection; a deselect starts the count afresh.
  always_ff @(posedge ref_clk) begin
    if (srst || host_select_n) begin
      edge_cnt_reg <= 4'h0;
    end else if (serial_clock_in && !sclk_d_reg && edge_cnt_reg != 4'hf) begin
      edge_cnt_reg <= edge_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || !serial_clock_in) begin
      high_cnt_reg <= 16'h0;
    end else begin
      high_cnt_reg <= high_cnt_reg + 16'h1;
    end
  end

  // Busy must have been visible for a while before the host is blamed for a command.
  always_ff @(posedge ref_clk) begin
    if (srst || busy_out_n) begin
      busy_cnt_reg <= 4'h0;
    end else if (busy_cnt_reg != 4'hf) begin
      busy_cnt_reg <= busy_cnt_reg + 4'h1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_FRAME_LEN: assert property ($rose(host_select_n) |-> edge_cnt_reg == (interface_select_pin ? 4'h9 : 4'h8))
    else $error("frame closed with wrong clock count");
  AST_STRAP_STATIC: assert property (!host_select_n |-> $stable(interface_select_pin))
    else $error("strap moved during a frame");
  AST_HALF_PERIOD: assert property ($fell(serial_clock_in) |-> 32'(high_cnt_reg) == HALF_CYCLES)
    else $error("link clock high phase has wrong length");
  AST_SERIAL_IN_LINE_STABLE: assert property (serial_clock_in && $past(serial_clock_in) |-> $stable(serial_in_line))
    else $error("serial data moved while clock high");
  AST_DC_STABLE: assert property (!interface_select_pin && serial_clock_in && $past(serial_clock_in)
    |-> $stable(data_command_sel))
    else $error("kind line moved while clock high");
  AST_DC_3W_LOW: assert property (interface_select_pin |-> !data_command_sel)
    else $error("kind line not low in three-wire mode");
  AST_SEL_CLK_LOW: assert property ($changed(host_select_n) |-> !serial_clock_in && host_reset_n)
    else $error("select changed with clock high or link in reset");
  AST_BUSY_CMD: assert property ($fell(host_select_n) && interface_select_pin && busy_cnt_reg > 4'h6
    |=> serial_in_line)
    else $error("command frame started while busy");
endmodule : esw_link_monitor

// ==== tb_top.sv ====
// Testbench: AXI4-Lite controller sending frames across the link to the display port.
`timescale 1ns/1ps
module tb_top;
  import esw_pkg::*;
  localparam int HALF = 4;
  logic ref_clk, srst, core_busy, rx_valid, rx_is_data, mode_3wire;
  logic [7:0] rx_byte;
  logic [15:0] cmd_count, data_count;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] pat [4] = '{8'h80, 8'h01, 8'hfe, 8'h7f};
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int n;

  esw_link_if link();
  esw_host #(.HALF_CYCLES(HALF)) esw_host_inst (
    .link(link), .ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  esw_dev esw_dev_inst (.link(link), .ref_clk, .srst, .core_busy, .rx_valid, .rx_byte, .rx_is_data,
    .mode_3wire, .cmd_count, .data_count);
  esw_link_monitor #(.HALF_CYCLES(HALF)) esw_link_monitor_inst (.ref_clk, .srst,
    .serial_clock_in(link.serial_clock_in), .host_select_n(link.host_select_n),
    .data_command_sel(link.data_command_sel), .serial_in_line(link.serial_in_line),
    .interface_select_pin(link.interface_select_pin), .host_reset_n(link.host_reset_n),
    .busy_out_n(link.busy_out_n));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic stop_test;
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Ready is sampled mid-cycle, so the handshake is known before the edge that completes it.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(negedge ref_clk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge ref_clk);
      if (ta) begin pa = 1'b0; s_axi_awvalid <= 1'b0; end
      if (tw) begin pw = 1'b0; s_axi_wvalid <= 1'b0; end
    end
    do begin @(negedge ref_clk); ta = s_axi_bvalid; r = s_axi_bresp; @(posedge ref_clk); end while (!ta);
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin @(negedge ref_clk); t = s_axi_arready; @(posedge ref_clk); end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin @(negedge ref_clk); t = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp; @(posedge ref_clk); end
    while (!t);
  endtask : axi_read

  task automatic wait_idle;
    do axi_read(OFS_STATUS, rd, rs); while (rd[ST_XFER_BIT] !== 1'b0);
  endtask : wait_idle

  task automatic send(input logic [7:0] b, input logic k);
    wait_idle();
    axi_write(OFS_TX, {23'h0, k, b}, rs);
  endtask : send

  task automatic wait_rx(input logic [7:0] b, input logic k);
    int i;
    i = 0;
    do begin @(negedge ref_clk); i++; end while (rx_valid !== 1'b1 && i < 400);
    chk({22'h0, rx_valid, rx_is_data, rx_byte}, {22'h1, k, b});
    @(posedge ref_clk);
  endtask : wait_rx

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin num_errors++; stop_test(); end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    srst = 1'b1; core_busy = 1'b0; s_axi_wstrb = 4'hf; s_axi_bready = 1'b1; s_axi_rready = 1'b1;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_arvalid = 1'b0;
    s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = 32'h0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    axi_read(OFS_CONFIG, rd, rs);
    chk({rd[30:0], mode_3wire}, 32'h0);
    wait_idle();
    axi_write(OFS_TX, 32'h0a5, rs);
    chk(32'(rs), 32'(RESP_OKAY));
    axi_write(OFS_TX, 32'h1ff, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    wait_rx(8'ha5, KIND_CMD);
    send(8'h3c, KIND_DATA);
    wait_rx(8'h3c, KIND_DATA);
    chk({cmd_count, data_count}, 32'h0001_0001);
    axi_read(4'hc, rd, rs);
    chk({rd[29:0], rs}, 32'h3);
    // A throwaway frame gives the strap synchronizer link clocks to settle on three-wire.
    wait_idle();
    axi_write(OFS_CONFIG, 32'h1, rs);
    send(8'h00, KIND_CMD);
    wait_idle();
    repeat (8) @(posedge ref_clk);
    chk(32'(mode_3wire), 32'h1);
    for (int i = 0; i < 4; i++) begin
      send(pat[i], i[0]);
      wait_rx(pat[i], i[0]);
    end
    core_busy <= 1'b1;
    repeat (8) @(posedge ref_clk);
    axi_read(OFS_STATUS, rd, rs);
    chk(32'({rd[ST_BUSY_OUT_N_BIT], link.busy_out_n}), 32'h0);
    send(8'h55, KIND_DATA);
    wait_rx(8'h55, KIND_DATA);
    send(8'haa, KIND_CMD);
    n = 0;
    repeat (200) begin @(negedge ref_clk); if (rx_valid === 1'b1) n++; end
    chk(32'(n), 32'h0);
    @(posedge ref_clk);
    core_busy <= 1'b0;
    wait_rx(8'haa, KIND_CMD);
    stop_test();
  end
endmodule : tb_top
